// [verilog/status_led_ctrl.sv]
// drive status indicator top: bridge, logic supply, port, network, error leds
// assumes pin levels are asynchronous and fieldbus signals share mclk
//
// Operation
// - bridge led green: bus powered, drive enabled
// - bridge led red while drive faulted
// - logic led green while 5 V present
// - port led: on link, flicker traffic, dark otherwise
// - network led steady in operational
// - preop: network led blinks 200/200 ms
// - safeop: network single flash 200/1000 ms
// - booting, bootstrap, download: network flicker 50/50
// - network led dark in init state
// - error led steady on PDI watchdog timeout
// - error led blinks on configuration error
// - error led flickers on boot error in init state, flag 0x01
// - error single flash on autonomous state change
// - error double flash on application watchdog
// - station alias held, set by master or setup
module status_led_ctrl import led_pkg::*; #(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire pin_in_t pins,
  input wire fieldbus_in_t fbus,
  input wire alias_in_t alias_in,
  output logic bridge_led_green,
  output logic bridge_led_red,
  output logic logic_supply_led,
  output logic [NUM_PORTS-1:0] port_link_activity_led,
  output logic network_state_led,
  output logic error_led,
  output logic [ALIAS_W-1:0] station_alias
);

  top_state_t q_reg;
  top_state_t q_next;
  pattern_t net_pat;
  pattern_t err_pat;
  logic net_on;
  logic err_on;
  logic [NUM_ERR-1:0] err_cond;
  logic [NUM_ERR-1:0] err_raised;

  // ----------------------------------------------------------------
  // error selection helpers
  // ----------------------------------------------------------------
  // fixed order breaks ties between conditions raised together and picks the fallback when the selected one clears
  function automatic err_sel_t pick_err(input logic [NUM_ERR-1:0] v);
    if (v[E_PDI_WD]) begin
      pick_err = ERR_PDI_WD;
    end else if (v[E_APP_WD]) begin
      pick_err = ERR_APP_WD;
    end else if (v[E_BOOT]) begin
      pick_err = ERR_BOOT;
    end else if (v[E_AUTO]) begin
      pick_err = ERR_AUTO_CHANGE;
    end else if (v[E_CONFIG]) begin
      pick_err = ERR_CONFIG;
    end else begin
      pick_err = ERR_NONE;
    end
  endfunction : pick_err

  function automatic logic sel_active(input err_sel_t s, input logic [NUM_ERR-1:0] v);
    case (s)
      ERR_PDI_WD: sel_active = v[E_PDI_WD];
      ERR_CONFIG: sel_active = v[E_CONFIG];
      ERR_BOOT: sel_active = v[E_BOOT];
      ERR_AUTO_CHANGE: sel_active = v[E_AUTO];
      ERR_APP_WD: sel_active = v[E_APP_WD];
      default: sel_active = 1'b0;
    endcase
  endfunction : sel_active

  // ----------------------------------------------------------------
  // pattern selection
  // ----------------------------------------------------------------
  // network led from fieldbus state; boot activity overrides
  always_comb begin
    if (fbus.booting || fbus.fw_download || fbus.state == ST_BOOT) begin
      net_pat = PAT_FLICKER;
    end else begin
      case (fbus.state)
        ST_OP: net_pat = PAT_ON;
        ST_PREOP: net_pat = PAT_BLINK;
        ST_SAFEOP: net_pat = PAT_SINGLE;
        default: net_pat = PAT_OFF;
      endcase
    end
  end

  // error conditions, boot and autonomous cases qualified by the flag
  always_comb begin
    err_cond = '0;
    err_cond[E_PDI_WD] = fbus.pdi_wd_timeout;
    err_cond[E_CONFIG] = fbus.config_error;
    err_cond[E_BOOT] = fbus.boot_error && fbus.state == ST_INIT
      && fbus.al_change == AL_CHANGE_ERR;
    err_cond[E_AUTO] = fbus.app_state_change && fbus.al_change == AL_CHANGE_ERR;
    err_cond[E_APP_WD] = fbus.app_wd_timeout;
    err_raised = err_cond & ~q_reg.err_prev;
  end

  // selected error to pattern
  always_comb begin
    case (q_reg.err_sel)
      ERR_PDI_WD: err_pat = PAT_ON;
      ERR_CONFIG: err_pat = PAT_BLINK;
      ERR_BOOT: err_pat = PAT_FLICKER;
      ERR_AUTO_CHANGE: err_pat = PAT_SINGLE;
      ERR_APP_WD: err_pat = PAT_DOUBLE;
      default: err_pat = PAT_OFF;
    endcase
  end

  // ----------------------------------------------------------------
  // pattern sequencers on the shared timebase
  // ----------------------------------------------------------------
  led_pattern_gen net_gen (
    .mclk(mclk),
    .rst_b(rst_b),
    .ms_tick(q_reg.ms_tick),
    .pattern(net_pat),
    .lit(net_on)
  );

  led_pattern_gen err_gen (
    .mclk(mclk),
    .rst_b(rst_b),
    .ms_tick(q_reg.ms_tick),
    .pattern(err_pat),
    .lit(err_on)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    q_next = q_reg;
    // two-stage pin synchroniser
    q_next.s1 = pins;
    q_next.s2 = q_reg.s1;

    // millisecond divider
    if (q_reg.ms_cnt == MS_CNT_W'(MS_CYCLES_P - 1)) begin
      q_next.ms_cnt = '0;
      q_next.ms_tick = 1'b1;
    end else begin
      q_next.ms_cnt = q_reg.ms_cnt + MS_CNT_W'(1);
      q_next.ms_tick = 1'b0;
    end

    // port flicker phase; traffic seen in a period drives the next one
    q_next.act_hold = q_reg.act_hold | q_reg.s2.activity;
    if (q_reg.ms_tick) begin
      if (q_reg.flk_cnt == FLK_CNT_W'(FLICKER_MS - 1)) begin
        q_next.flk_cnt = '0;
        q_next.flk_phase = ~q_reg.flk_phase;
        if (q_reg.flk_phase) begin
          q_next.port_active = q_reg.act_hold | q_reg.s2.activity;
          q_next.act_hold = '0;
        end
      end else begin
        q_next.flk_cnt = q_reg.flk_cnt + FLK_CNT_W'(1);
      end
    end
    q_next.port_led = q_reg.s2.link
      & (~q_reg.port_active | {NUM_PORTS{~q_reg.flk_phase}});

    // bridge and logic supply indication
    q_next.bridge_green = q_reg.s2.dc_bus_present && q_reg.s2.drive_enabled
      && !q_reg.s2.drive_fault;
    q_next.bridge_red = q_reg.s2.drive_fault;
    q_next.logic_led = q_reg.s2.logic_supply_ok;

    // latest raised condition wins; fall back when it clears
    q_next.err_prev = err_cond;
    if (|err_raised) begin
      q_next.err_sel = pick_err(err_raised);
    end else if (!sel_active(q_reg.err_sel, err_cond)) begin
      q_next.err_sel = pick_err(err_cond);
    end

    // alias store, network write first
    if (alias_in.master_we) begin
      q_next.station_alias = alias_in.master_alias;
    end else if (alias_in.setup_we) begin
      q_next.station_alias = alias_in.setup_alias;
    end

    q_next.net_led = net_on;
    q_next.err_led = err_on;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  // outputs straight from state
  assign bridge_led_green = q_reg.bridge_green;
  assign bridge_led_red = q_reg.bridge_red;
  assign logic_supply_led = q_reg.logic_led;
  assign port_link_activity_led = q_reg.port_led;
  assign network_state_led = q_reg.net_led;
  assign error_led = q_reg.err_led;
  assign station_alias = q_reg.station_alias;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_bridge_green: assert property (
    (pins.dc_bus_present && pins.drive_enabled && !pins.drive_fault) [*4]
      |-> bridge_led_green && !bridge_led_red)
    else $error("bridge led not green when powered and enabled");
  a_bridge_red: assert property (
    pins.drive_fault [*4] |-> bridge_led_red && !bridge_led_green)
    else $error("bridge led not red on fault");
  a_logic_supply: assert property (
    pins.logic_supply_ok [*4] |-> logic_supply_led)
    else $error("logic supply led dark with supply present");
  a_port_dark: assert property (
    !pins.link[0] [*4] |-> !port_link_activity_led[0])
    else $error("port led lit without link");
  a_port_steady: assert property (
    pins.link[0] && !q_reg.port_active[0] ##1 pins.link[0] [*3]
      |-> port_link_activity_led[0])
    else $error("port led not steady on idle link");
  a_net_operational: assert property (
    (fbus.state == ST_OP && !fbus.booting && !fbus.fw_download) [*3]
      |-> network_state_led)
    else $error("network led dark in operational");
  a_net_init_dark: assert property (
    (fbus.state == ST_INIT && !fbus.booting && !fbus.fw_download) [*3]
      |-> !network_state_led)
    else $error("network led lit in init");
  a_pdi_steady: assert property (
    q_reg.err_sel == ERR_PDI_WD [*3] |-> error_led)
    else $error("error led not steady for watchdog");
  a_latest_error: assert property (
    err_raised == 5'h02 |=> q_reg.err_sel == ERR_CONFIG)
    else $error("latest raised error not selected");
  a_boot_error_flag: assert property (
    fbus.boot_error && fbus.al_change != AL_CHANGE_ERR && !q_reg.err_prev[E_BOOT]
      |=> q_reg.err_sel != ERR_BOOT)
    else $error("boot error selected without flag");

  // each single raised condition selects its own pattern
  a_pdi_select: assert property (
    err_raised == 5'h01 |=> q_reg.err_sel == ERR_PDI_WD)
    else $error("pdi watchdog not selected");
  a_boot_select: assert property (
    err_raised == 5'h04 |=> q_reg.err_sel == ERR_BOOT)
    else $error("boot error not selected");
  a_auto_select: assert property (
    err_raised == 5'h08 |=> q_reg.err_sel == ERR_AUTO_CHANGE)
    else $error("autonomous change not selected");
  a_appwd_select: assert property (
    err_raised == 5'h10 |=> q_reg.err_sel == ERR_APP_WD)
    else $error("application watchdog not selected");
  a_sel_was_active: assert property (
    q_reg.err_sel != ERR_NONE |-> sel_active(q_reg.err_sel, q_reg.err_prev))
    else $error("selected error not active");
  a_err_dark: assert property (
    (err_cond == 5'h00) [*4] |-> !error_led)
    else $error("error led lit with no condition");

  // alias store takes writes and keeps its word between them; port 1 dark and ms tick checks
  a_alias_setup: assert property (
    alias_in.setup_we && !alias_in.master_we
      |=> station_alias == $past(alias_in.setup_alias))
    else $error("setup alias not stored");
  a_alias_hold: assert property (
    !alias_in.master_we && !alias_in.setup_we |=> $stable(station_alias))
    else $error("station alias changed without write");
  a_port1_dark: assert property (
    !pins.link[1] [*4] |-> !port_link_activity_led[1])
    else $error("port led lit without link");
  a_alias_write: assert property (
    alias_in.master_we |=> station_alias == $past(alias_in.master_alias))
    else $error("station alias not stored");
  a_ms_tick_gap: assert property (
    q_reg.ms_tick |=> !q_reg.ms_tick)
    else $error("ms tick longer than one cycle");

  c_preop_blink: cover property (fbus.state == ST_PREOP ##1 network_state_led);
  c_port_flicker: cover property (q_reg.port_active[0] && port_link_activity_led[0]
    ##1 !port_link_activity_led[0]);
  c_error_switch: cover property (q_reg.err_sel == ERR_APP_WD ##1 q_reg.err_sel == ERR_CONFIG);
  c_alias_setup: cover property (alias_in.setup_we && !alias_in.master_we);
  c_double_flash: cover property (q_reg.err_sel == ERR_APP_WD ##1 error_led);

endmodule : status_led_ctrl

// [verilog/led_pkg.sv]
// status indicator package: timing, codes, carriers and state types
// assumes one 125 MHz clock; pattern timing runs off a 1 ms enable pulse
package led_pkg;

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int MS_CNT_W = 17;

  // ----------------------------------------------------------------
  // pattern phase lengths in ms
  // ----------------------------------------------------------------
  localparam int FLASH_ON_MS = 200;
  localparam int BLINK_OFF_MS = 200;
  localparam int FLASH_GAP_MS = 200;
  localparam int FLASH_PAUSE_MS = 1000;
  localparam int FLICKER_MS = 50;
  localparam int BLINK_PERIOD_MS = FLASH_ON_MS + BLINK_OFF_MS;
  localparam int SINGLE_PERIOD_MS = FLASH_ON_MS + FLASH_PAUSE_MS;
  localparam int DOUBLE_PERIOD_MS = 2 * FLASH_ON_MS + FLASH_GAP_MS + FLASH_PAUSE_MS;
  localparam int FLICKER_PERIOD_MS = 2 * FLICKER_MS;
  localparam int PAT_MS_W = 11;
  localparam int FLK_CNT_W = 6;

  // ----------------------------------------------------------------
  // widths and codes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 2;
  localparam int ALIAS_W = 16;
  localparam int NUM_ERR = 5;
  localparam logic [7:0] AL_CHANGE_ERR = 8'h01;
  localparam logic [3:0] ST_INIT = 4'h1;
  localparam logic [3:0] ST_PREOP = 4'h2;
  localparam logic [3:0] ST_BOOT = 4'h3;
  localparam logic [3:0] ST_SAFEOP = 4'h4;
  localparam logic [3:0] ST_OP = 4'h8;
  // error condition bit positions
  localparam int E_PDI_WD = 0;
  localparam int E_CONFIG = 1;
  localparam int E_BOOT = 2;
  localparam int E_AUTO = 3;
  localparam int E_APP_WD = 4;

  typedef enum logic [2:0] {
    PAT_OFF, PAT_ON, PAT_BLINK, PAT_SINGLE, PAT_DOUBLE, PAT_FLICKER
  } pattern_t;

  typedef enum logic [2:0] {
    ERR_NONE, ERR_PDI_WD, ERR_CONFIG, ERR_BOOT, ERR_AUTO_CHANGE, ERR_APP_WD
  } err_sel_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic dc_bus_present;
    logic drive_enabled;
    logic drive_fault;
    logic logic_supply_ok;
    logic [NUM_PORTS-1:0] link;
    logic [NUM_PORTS-1:0] activity;
  } pin_in_t;

  typedef struct packed {
    logic [3:0] state;
    logic booting;
    logic fw_download;
    logic [7:0] al_change;
    logic pdi_wd_timeout;
    logic config_error;
    logic boot_error;
    logic app_state_change;
    logic app_wd_timeout;
  } fieldbus_in_t;

  typedef struct packed {
    logic master_we;
    logic [ALIAS_W-1:0] master_alias;
    logic setup_we;
    logic [ALIAS_W-1:0] setup_alias;
  } alias_in_t;

  // ----------------------------------------------------------------
  // module state
  // ----------------------------------------------------------------
  typedef struct packed {
    pattern_t cur;
    logic [PAT_MS_W-1:0] ms;
    logic on;
  } pat_state_t;

  typedef struct packed {
    pin_in_t s1;
    pin_in_t s2;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic ms_tick;
    logic [FLK_CNT_W-1:0] flk_cnt;
    logic flk_phase;
    logic [NUM_PORTS-1:0] act_hold;
    logic [NUM_PORTS-1:0] port_active;
    logic [NUM_PORTS-1:0] port_led;
    logic [NUM_ERR-1:0] err_prev;
    err_sel_t err_sel;
    logic bridge_green;
    logic bridge_red;
    logic logic_led;
    logic net_led;
    logic err_led;
    logic [ALIAS_W-1:0] station_alias;
  } top_state_t;

endpackage : led_pkg

// [verilog/led_pattern_gen.sv]
// one led pattern sequencer: off, on, blink, single, double flash, flicker
// assumes a one-cycle ms_tick enable from a shared millisecond divider
module led_pattern_gen import led_pkg::*; (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ms_tick,
  input wire pattern_t pattern,
  output logic lit
);

  pat_state_t q_reg;
  pat_state_t q_next;

  // ----------------------------------------------------------------
  // pattern decode
  // ----------------------------------------------------------------
  function automatic logic [PAT_MS_W-1:0] period_of(input pattern_t p);
    case (p)
      PAT_BLINK: period_of = PAT_MS_W'(BLINK_PERIOD_MS);
      PAT_SINGLE: period_of = PAT_MS_W'(SINGLE_PERIOD_MS);
      PAT_DOUBLE: period_of = PAT_MS_W'(DOUBLE_PERIOD_MS);
      PAT_FLICKER: period_of = PAT_MS_W'(FLICKER_PERIOD_MS);
      default: period_of = PAT_MS_W'(1);
    endcase
  endfunction : period_of

  function automatic logic lit_of(input pattern_t p, input logic [PAT_MS_W-1:0] ms);
    case (p)
      PAT_ON: lit_of = 1'b1;
      PAT_BLINK: lit_of = (ms < PAT_MS_W'(FLASH_ON_MS));
      PAT_SINGLE: lit_of = (ms < PAT_MS_W'(FLASH_ON_MS));
      PAT_DOUBLE: lit_of = (ms < PAT_MS_W'(FLASH_ON_MS))
        || (ms >= PAT_MS_W'(FLASH_ON_MS + FLASH_GAP_MS)
        && ms < PAT_MS_W'(2 * FLASH_ON_MS + FLASH_GAP_MS));
      PAT_FLICKER: lit_of = (ms < PAT_MS_W'(FLICKER_MS));
      default: lit_of = 1'b0;
    endcase
  endfunction : lit_of

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // restart on change, else step one ms per tick and wrap at the period
  always_comb begin
    q_next = q_reg;
    if (pattern != q_reg.cur) begin
      q_next.cur = pattern;
      q_next.ms = '0;
    end else if (ms_tick) begin
      if (q_reg.ms >= period_of(q_reg.cur) - PAT_MS_W'(1)) begin
        q_next.ms = '0;
      end else begin
        q_next.ms = q_reg.ms + PAT_MS_W'(1);
      end
    end
    q_next.on = lit_of(q_next.cur, q_next.ms);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign lit = q_reg.on;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_restart_on_change: assert property (
    pattern != q_reg.cur && pattern != PAT_OFF |=> q_reg.ms == '0 && lit)
    else $error("pattern change did not restart in on phase");
  a_blink_phases: assert property (
    q_reg.cur == PAT_BLINK |-> lit == (q_reg.ms < 11'hc8))
    else $error("blink phase wrong");
  a_single_flash: assert property (
    q_reg.cur == PAT_SINGLE && q_reg.ms >= 11'hc8 |-> !lit && q_reg.ms < 11'h4b0)
    else $error("single flash off phase wrong");
  a_flicker_phases: assert property (
    q_reg.cur == PAT_FLICKER |-> lit == (q_reg.ms < 11'h32) && q_reg.ms < 11'h64)
    else $error("flicker phase wrong");
  a_double_flash: assert property (
    q_reg.cur == PAT_DOUBLE |-> lit == (q_reg.ms < 11'hc8
      || (q_reg.ms >= 11'h190 && q_reg.ms < 11'h258)))
    else $error("double flash phase wrong");

endmodule : led_pattern_gen

// [tb/master_model.sv]
// partner model: network side that sets fieldbus state, error flags and alias
// assumes the bench calls its tasks; every change lands on a falling edge
module master_model import led_pkg::*; (
  input wire logic mclk,
  output fieldbus_in_t fbus,
  output alias_in_t alias_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle: state code 0, no errors, no writes
  initial begin
    fbus = '0;
    alias_in = '0;
  end

  // commanded state and boot flags
  task automatic set_state(input logic [3:0] st, input logic boot, input logic dl);
    @(negedge mclk);
    fbus.state = st;
    fbus.booting = boot;
    fbus.fw_download = dl;
  endtask : set_state

  // error condition levels and change flag
  task automatic set_err(input logic [NUM_ERR-1:0] e, input logic [7:0] al);
    @(negedge mclk);
    fbus.pdi_wd_timeout = e[E_PDI_WD];
    fbus.config_error = e[E_CONFIG];
    fbus.boot_error = e[E_BOOT];
    fbus.app_state_change = e[E_AUTO];
    fbus.app_wd_timeout = e[E_APP_WD];
    fbus.al_change = al;
  endtask : set_err

  // one-cycle alias write; both write enables drop on the next falling edge
  task automatic write_alias(input logic mw, input logic [ALIAS_W-1:0] md,
                             input logic sw, input logic [ALIAS_W-1:0] sd);
    @(negedge mclk);
    alias_in = {mw, md, sw, sd};
    @(negedge mclk);
    alias_in.master_we = 1'b0;
    alias_in.setup_we = 1'b0;
  endtask : write_alias
endmodule : master_model

// [tb/tb_status_led_ctrl.sv]
// self-checking bench for the status indicator top
// assumes a shortened ms tick of MSC cycles; inputs change on falling edges
module tb_status_led_ctrl import led_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // timing and signals
  // ----------------------------------------------------------------
  localparam int MSC = 5;
  localparam int T_ON = FLASH_ON_MS * MSC;
  localparam int T_PAUSE = FLASH_PAUSE_MS * MSC;
  localparam int T_FLK = FLICKER_MS * MSC;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  pin_in_t pins = '0;
  fieldbus_in_t fbus;
  alias_in_t alias_in;
  logic bridge_led_green, bridge_led_red, logic_supply_led;
  logic [NUM_PORTS-1:0] port_link_activity_led;
  logic network_state_led, error_led;
  logic [ALIAS_W-1:0] station_alias;
  int n_fail = 0;
  int check_count = 0;
  int wsel = 0;
  logic watched;

  // clock
  initial begin
    forever #4 mclk = ~mclk;
  end

  // led under measurement
  always_comb begin
    case (wsel)
      0: watched = network_state_led;
      1: watched = error_led;
      default: watched = port_link_activity_led[wsel[0]];
    endcase
  end

  status_led_ctrl #(.MS_CYCLES_P(MSC)) i_status_led_ctrl (
    .mclk(mclk), .rst_b(rst_b), .pins(pins), .fbus(fbus), .alias_in(alias_in),
    .bridge_led_green(bridge_led_green), .bridge_led_red(bridge_led_red),
    .logic_supply_led(logic_supply_led), .port_link_activity_led(port_link_activity_led),
    .network_state_led(network_state_led), .error_led(error_led),
    .station_alias(station_alias));

  master_model m_master (.mclk(mclk), .fbus(fbus), .alias_in(alias_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [NUM_ERR-1:0] eb(input int i);
    return NUM_ERR'(1) << i;
  endfunction : eb

  // cycles the watched led keeps one level, bounded
  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (watched === lvl && n < 20000) begin
      @(negedge mclk);
      n++;
    end
  endtask : run_len

  // skip to the end of an on phase, then measure off, on and an optional off
  task automatic pat(input string name, input int a, input int b, input int c, input bit first);
    int n;
    repeat (3) @(negedge mclk);
    if (first) check({name, " start"}, 16'(watched), 16'h0001);
    run_len(1'b0, n);
    run_len(1'b1, n);
    run_len(1'b0, n);
    check({name, " off"}, 16'(n), 16'(a));
    run_len(1'b1, n);
    check({name, " on"}, 16'(n), 16'(b));
    if (c > 0) begin
      run_len(1'b0, n);
      check({name, " pause"}, 16'(n), 16'(c));
    end
  endtask : pat

  // steady level now and after a blink on phase would have ended
  task automatic hold(input string name, input logic exp);
    repeat (3) @(negedge mclk);
    check({name, " now"}, 16'(watched), 16'(exp));
    repeat (2100) @(negedge mclk);
    check({name, " later"}, 16'(watched), 16'(exp));
  endtask : hold

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_bridge();
    logic [3:0] v [4] = '{4'h0d, 4'h0f, 4'h05, 4'h08};
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      {pins.dc_bus_present, pins.drive_enabled, pins.drive_fault, pins.logic_supply_ok} = v[i];
      repeat (3) @(negedge mclk);
      check("bridge green", 16'(bridge_led_green), 16'(v[i][3] & v[i][2] & !v[i][1]));
      check("bridge red", 16'(bridge_led_red), 16'(v[i][1]));
      check("logic supply", 16'(logic_supply_led), 16'(v[i][0]));
    end
  endtask : t_bridge

  task automatic t_port();
    for (int p = 0; p < NUM_PORTS; p++) begin
      wsel = 2 + p;
      @(negedge mclk);
      pins.link = NUM_PORTS'(1) << p;
      hold("port link idle", 1'b1);
      check("other port", 16'(port_link_activity_led[1-p]), 16'h0000);
      @(negedge mclk);
      pins.activity = NUM_PORTS'(1) << p;
      pat("port traffic", T_FLK, T_FLK, 0, 1'b0);
      @(negedge mclk);
      pins.link = '0;
      pins.activity = '0;
      hold("port no link", 1'b0);
    end
  endtask : t_port

  task automatic t_net();
    wsel = 0;
    m_master.set_state(ST_OP, 1'b0, 1'b0);
    hold("net op", 1'b1);
    m_master.set_state(ST_PREOP, 1'b0, 1'b0);
    pat("net preop", T_ON, T_ON, 0, 1'b1);
    m_master.set_state(ST_SAFEOP, 1'b0, 1'b0);
    pat("net safeop", T_PAUSE, T_ON, 0, 1'b1);
    m_master.set_state(ST_BOOT, 1'b0, 1'b0);
    pat("net bootstrap", T_FLK, T_FLK, 0, 1'b1);
    m_master.set_state(ST_INIT, 1'b1, 1'b0);
    pat("net booting", T_FLK, T_FLK, 0, 1'b0);
    m_master.set_state(ST_OP, 1'b0, 1'b1);
    pat("net download", T_FLK, T_FLK, 0, 1'b0);
    m_master.set_state(ST_INIT, 1'b0, 1'b0);
    hold("net init", 1'b0);
  endtask : t_net

  task automatic t_err();
    wsel = 1;
    m_master.set_err(eb(E_PDI_WD), 8'h00);
    hold("err pdi", 1'b1);
    m_master.set_err(eb(E_CONFIG), 8'h00);
    pat("err config", T_ON, T_ON, 0, 1'b1);
    m_master.set_err(eb(E_CONFIG) | eb(E_PDI_WD), 8'h00);
    hold("err latest", 1'b1);
    m_master.set_err(eb(E_CONFIG), 8'h00);
    pat("err fallback", T_ON, T_ON, 0, 1'b1);
    m_master.set_err(eb(E_BOOT), AL_CHANGE_ERR);
    pat("err boot", T_FLK, T_FLK, 0, 1'b1);
    m_master.set_err(eb(E_AUTO), AL_CHANGE_ERR);
    pat("err auto", T_PAUSE, T_ON, 0, 1'b1);
    m_master.set_err(eb(E_APP_WD), 8'h00);
    pat("err app wd", T_ON, T_ON, T_PAUSE, 1'b1);
    m_master.set_err(eb(E_BOOT), 8'h00);
    hold("err unflagged", 1'b0);
  endtask : t_err

  task automatic t_alias();
    m_master.write_alias(1'b1, 16'h1234, 1'b0, 16'h0000);
    check("alias master", station_alias, 16'h1234);
    m_master.write_alias(1'b0, 16'h0000, 1'b1, 16'habcd);
    check("alias setup", station_alias, 16'habcd);
    m_master.write_alias(1'b1, 16'h5a5a, 1'b1, 16'ha5a5);
    repeat (5) @(negedge mclk);
    check("alias both held", station_alias, 16'h5a5a);
  endtask : t_alias

  // main sequence
  initial begin
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    t_bridge();
    t_port();
    t_net();
    t_err();
    t_alias();
    give_verdict();
  end

  // watchdog
  initial begin
    repeat (80000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
endmodule : tb_status_led_ctrl
